// File: hdl/asp_pkg.sv
/*
  Shared constants and types for the asynchronous serial port.
  Assumes a byte-wide register port with 16-bit addresses in the device.
*/
package asp_pkg;
  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam int ASP_AW = 16;
  localparam logic [15:0] ASP_ADDR_MODE = 16'hFFA0;
  localparam logic [15:0] ASP_ADDR_STAT = 16'hFFA1;
  localparam logic [15:0] ASP_ADDR_BAUD = 16'hFFA2;
  localparam logic [15:0] ASP_ADDR_DATA = 16'hFFA3;
  localparam logic [7:0] ASP_MODE_RST = 8'h00;
  localparam logic [7:0] ASP_STAT_RST = 8'h00;
  localparam logic [7:0] ASP_BAUD_RST = 8'h00;
  localparam logic [7:0] ASP_TXS_RST = 8'hFF;
  localparam logic [7:0] ASP_RXB_RST = 8'hFF;
  localparam logic [7:0] ASP_BAUD_MASK = 8'h7F;
  localparam logic [7:0] ASP_UNMAPPED = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ASP_ST_PE = 2;
  localparam int ASP_ST_FE = 1;
  localparam int ASP_ST_OVE = 0;
  localparam int ASP_MODE_FIXED0 = 0;
  localparam logic [4:0] ASP_MDL_BASE = 5'h10;
  // ****************************************
  // Parity encodings and timing
  // ****************************************
  localparam logic [1:0] ASP_PAR_NONE = 2'h0;
  localparam logic [1:0] ASP_PAR_ZERO = 2'h1;
  localparam logic [1:0] ASP_PAR_ODD = 2'h2;
  localparam logic [1:0] ASP_PAR_EVEN = 2'h3;
  localparam int ASP_CLK_HZ = 50_000_000;
  localparam int ASP_MIDI_BPS = 31_250;
  localparam int ASP_MIDI_CYC = ASP_CLK_HZ / ASP_MIDI_BPS;

  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic parity_select_hi;
    logic parity_select_lo;
    logic char_length_bit;
    logic stop_length_bit;
    logic error_irq_suppress;
    logic fixed0;
  } asp_mode_t;

  typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_PAR, ASP_STOP} asp_st_t;
endpackage

// File: hdl/asp_serial_port.sv
/*
  Asynchronous serial port: mode, status and baud registers, transmit
  queue, transmitter and receiver. Assumes the core register port strobes
  are synchronous to clk_sys and the serial input is already synchronous.
*/
`timescale 1ns/1ps

module asp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Asynchronous reset
  input wire logic [WIDTH-1:0] in_data, // Word to store
  input wire logic in_valid, // Store request
  output logic in_ready, // Room left
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic out_valid, // Word available
  input wire logic out_ready // Drain request
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("asp_fifo: DEPTH must be a power of two");
  end

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? wp_q + AW'(1'b1) : wp_q;
    rp_d = pop ? rp_q + AW'(1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wp_q] <= in_data;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

module asp_serial_port #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [asp_pkg::ASP_AW-1:0] bus_addr, // Register address
  input wire logic bus_wr, // Byte write strobe
  input wire logic bus_rd, // Byte read strobe
  input wire logic bus_bit_wr, // Single-bit write strobe
  input wire logic [2:0] bus_bit_sel, // Bit number for bit write
  input wire logic bus_bit_val, // Bit value for bit write
  input wire logic [7:0] bus_wdata, // Write data
  output logic [7:0] bus_rdata_q, // Read data, one cycle after read
  output logic tx_space_q, // Transmit queue can take a byte
  output logic rx_avail_q, // Receive buffer holds unread data
  output logic rx_event_q, // Receive completion pulse
  input wire logic serial_in_pin, // Serial receive line
  output logic serial_out_pin_q, // Serial transmit line
  output logic serial_out_oe_n_q // Transmit pin enable, low drives
);
  import asp_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // Half a bit time: (16 + k) << n; a zero prescale code acts as one
  function automatic logic [11:0] half_bit(input logic [7:0] b);
    logic [2:0] n;
    n = (b[6:4] == 3'h0) ? 3'h1 : b[6:4];
    return {7'h00, ASP_MDL_BASE} + {8'h00, b[3:0]} << n;
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] p);
    case (p)
      ASP_PAR_ODD: return ~^d;
      ASP_PAR_EVEN: return ^d;
      default: return 1'b0;
    endcase
  endfunction

  asp_mode_t mode_q, mode_d;
  logic [7:0] stat_q, stat_d, baud_q, baud_d, rxb_q, rxb_d, rdata_d;
  logic rxf_q, rxf_d, evt_d;
  logic [11:0] hb;
  logic [12:0] blen;
  logic [1:0] par;
  logic [2:0] last_bit;
  logic rd_data, rd_stat, wr_data;

  always_comb begin
    hb = half_bit(baud_q);
    blen = {hb, 1'b0};
    par = {mode_q.parity_select_hi, mode_q.parity_select_lo};
    last_bit = mode_q.char_length_bit ? 3'h7 : 3'h6;
    rd_data = bus_rd && bus_addr == ASP_ADDR_DATA;
    rd_stat = bus_rd && bus_addr == ASP_ADDR_STAT;
    wr_data = bus_wr && bus_addr == ASP_ADDR_DATA;
  end

  // ****************************************
  // Transmit queue and transmitter
  // ****************************************
  asp_st_t tx_st_q, tx_st_d;
  logic [12:0] tx_cnt_q, tx_cnt_d;
  logic [7:0] txs_q, txs_d, q_data;
  logic [2:0] tx_nb_q, tx_nb_d;
  logic tx_pb_q, tx_pb_d, txd_d, q_valid, q_ready, q_in_ready, tx_load;

  // Writes while disabled are dropped rather than queued for later
  asp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(bus_wdata),
    .in_valid(wr_data && mode_q.tx_enable_bit),
    .in_ready(q_in_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  always_comb begin
    q_ready = tx_st_q == ASP_IDLE && mode_q.tx_enable_bit;
    tx_load = q_valid && q_ready;
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    txs_d = txs_q;
    tx_nb_d = tx_nb_q;
    tx_pb_d = tx_pb_q;
    txd_d = serial_out_pin_q;
    if (!mode_q.tx_enable_bit) begin
      tx_st_d = ASP_IDLE;
      txd_d = 1'b1;
    end else if (tx_st_q == ASP_IDLE) begin
      txd_d = 1'b1;
      if (tx_load) begin
        txs_d = mode_q.char_length_bit ? q_data : {1'b0, q_data[6:0]};
        tx_pb_d = par_bit(txs_d, par);
        tx_st_d = ASP_START;
        tx_cnt_d = blen - 13'h0001;
        txd_d = 1'b0;
      end
    end else if (tx_cnt_q != 13'h0000) begin
      tx_cnt_d = tx_cnt_q - 13'h0001;
    end else begin
      tx_cnt_d = blen - 13'h0001;
      case (tx_st_q)
        ASP_START: begin
          txd_d = txs_q[0];
          txs_d = {1'b1, txs_q[7:1]};
          tx_nb_d = 3'h0;
          tx_st_d = ASP_DATA;
        end
        ASP_DATA: begin
          tx_nb_d = tx_nb_q + 3'h1;
          txd_d = txs_q[0];
          txs_d = {1'b1, txs_q[7:1]};
          if (tx_nb_q == last_bit) begin
            tx_nb_d = 3'h0;
            tx_st_d = (par == ASP_PAR_NONE) ? ASP_STOP : ASP_PAR;
            txd_d = (par == ASP_PAR_NONE) ? 1'b1 : tx_pb_q;
          end
        end
        ASP_PAR: begin
          txd_d = 1'b1;
          tx_st_d = ASP_STOP;
        end
        ASP_STOP: begin
          if (mode_q.stop_length_bit && tx_nb_q == 3'h0) tx_nb_d = 3'h1;
          else tx_st_d = ASP_IDLE;
        end
        default: tx_st_d = ASP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_q <= ASP_IDLE;
      tx_cnt_q <= 13'h0000;
      txs_q <= ASP_TXS_RST;
      tx_nb_q <= 3'h0;
      tx_pb_q <= 1'b0;
      serial_out_pin_q <= 1'b1;
      serial_out_oe_n_q <= 1'b1;
      tx_space_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      txs_q <= txs_d;
      tx_nb_q <= tx_nb_d;
      tx_pb_q <= tx_pb_d;
      serial_out_pin_q <= txd_d;
      serial_out_oe_n_q <= !mode_q.tx_enable_bit;
      tx_space_q <= q_in_ready && mode_q.tx_enable_bit;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  asp_st_t rx_st_q, rx_st_d;
  logic [12:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rxs_q, rxs_d, rx_word;
  logic [2:0] rx_nb_q, rx_nb_d;
  logic rx_pb_q, rx_pb_d, rx_done, rx_fe, rx_pe;

  // Own counter and shifter, so reception never waits on the transmitter
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rxs_d = rxs_q;
    rx_nb_d = rx_nb_q;
    rx_pb_d = rx_pb_q;
    rx_done = 1'b0;
    rx_fe = 1'b0;
    rx_word = mode_q.char_length_bit ? rxs_q : {1'b0, rxs_q[7:1]};
    rx_pe = (par == ASP_PAR_ODD || par == ASP_PAR_EVEN) && rx_pb_q != par_bit(rx_word, par);
    if (!mode_q.rx_enable_bit) begin
      rx_st_d = ASP_IDLE;
    end else if (rx_st_q == ASP_IDLE) begin
      if (!serial_in_pin) begin
        rx_st_d = ASP_START;
        rx_cnt_d = 13'(hb) - 13'h0001;
      end
    end else if (rx_cnt_q != 13'h0000) begin
      rx_cnt_d = rx_cnt_q - 13'h0001;
    end else begin
      rx_cnt_d = blen - 13'h0001;
      case (rx_st_q)
        ASP_START: begin
          rx_nb_d = 3'h0;
          rx_st_d = serial_in_pin ? ASP_IDLE : ASP_DATA;
        end
        ASP_DATA: begin
          rxs_d = {serial_in_pin, rxs_q[7:1]};
          rx_nb_d = rx_nb_q + 3'h1;
          if (rx_nb_q == last_bit) rx_st_d = (par == ASP_PAR_NONE) ? ASP_STOP : ASP_PAR;
        end
        ASP_PAR: begin
          rx_pb_d = serial_in_pin;
          rx_st_d = ASP_STOP;
        end
        ASP_STOP: begin
          rx_done = 1'b1;
          rx_fe = !serial_in_pin;
          rx_st_d = ASP_IDLE;
        end
        default: rx_st_d = ASP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q <= ASP_IDLE;
      rx_cnt_q <= 13'h0000;
      rxs_q <= 8'h00;
      rx_nb_q <= 3'h0;
      rx_pb_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rxs_q <= rxs_d;
      rx_nb_q <= rx_nb_d;
      rx_pb_q <= rx_pb_d;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] mb;
  logic ove;

  always_comb begin
    mb = mode_q;
    baud_d = baud_q;
    stat_d = rd_stat ? ASP_STAT_RST : stat_q;
    rxb_d = rxb_q;
    rxf_d = rxf_q && !rd_data;
    rdata_d = bus_rdata_q;
    evt_d = 1'b0;
    ove = 1'b0;
    if (bus_wr && bus_addr == ASP_ADDR_MODE) mb = bus_wdata;
    if (bus_bit_wr && bus_addr == ASP_ADDR_MODE) mb[bus_bit_sel] = bus_bit_val;
    mb[ASP_MODE_FIXED0] = 1'b0;
    mode_d = asp_mode_t'(mb);
    if (bus_wr && bus_addr == ASP_ADDR_BAUD) baud_d = bus_wdata & ASP_BAUD_MASK;
    if (bus_rd) begin
      case (bus_addr)
        ASP_ADDR_MODE: rdata_d = mode_q;
        ASP_ADDR_STAT: rdata_d = stat_q;
        ASP_ADDR_BAUD: rdata_d = baud_q;
        ASP_ADDR_DATA: rdata_d = rxb_q;
        default: rdata_d = ASP_UNMAPPED;
      endcase
    end
    if (rx_done) begin
      ove = rxf_q && !rd_data;
      stat_d[ASP_ST_OVE] = stat_d[ASP_ST_OVE] | ove;
      stat_d[ASP_ST_FE] = stat_d[ASP_ST_FE] | rx_fe;
      stat_d[ASP_ST_PE] = stat_d[ASP_ST_PE] | rx_pe;
      rxf_d = 1'b1;
      if (!ove) rxb_d = rx_word;
      evt_d = !(mode_q.error_irq_suppress && (ove || rx_fe || rx_pe));
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= asp_mode_t'(ASP_MODE_RST);
      baud_q <= ASP_BAUD_RST;
      stat_q <= ASP_STAT_RST;
      rxb_q <= ASP_RXB_RST;
      rxf_q <= 1'b0;
      bus_rdata_q <= 8'h00;
      rx_avail_q <= 1'b0;
      rx_event_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      baud_q <= baud_d;
      stat_q <= stat_d;
      rxb_q <= rxb_d;
      rxf_q <= rxf_d;
      bus_rdata_q <= rdata_d;
      rx_avail_q <= rxf_d;
      rx_event_q <= evt_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence tx_launch;
    tx_load ##1 (serial_out_pin_q == 1'b0);
  endsequence

  tx_start_low_a: assert property (tx_load |-> tx_launch) else $error("no start bit");
  tx_idle_high_a: assert property (tx_st_q == ASP_IDLE |-> serial_out_pin_q)
    else $error("line not idle high");
  tx_bit_hold_a: assert property (tx_st_q != ASP_IDLE && tx_cnt_q != 13'h0000
    && mode_q.tx_enable_bit |=> $stable(serial_out_pin_q)) else $error("bit cut short");
  tx_stop_mode_a: assert property (!mode_q.tx_enable_bit |=> tx_st_q == ASP_IDLE)
    else $error("transmitter runs while stopped");
  rx_seven_bit_a: assert property (rx_done && !ove && !mode_q.char_length_bit
    |=> !rxb_q[7]) else $error("bit 7 set in seven-bit mode");
  rx_overrun_a: assert property (rx_done && rxf_q && !rd_data |=> stat_q[ASP_ST_OVE])
    else $error("overrun not flagged");
  rx_framing_a: assert property (rx_done && !serial_in_pin |=> stat_q[ASP_ST_FE])
    else $error("framing error lost");
  mode_fixed_a: assert property (mode_q.fixed0 == 1'b0) else $error("mode bit 0 set");
  data_read_a: assert property (rd_data |=> bus_rdata_q == $past(rxb_q))
    else $error("data read not from buffer");
  tx_enable_bit_a: assert property (bus_bit_wr && bus_addr == ASP_ADDR_MODE
    && bus_bit_sel == 3'h7 && !bus_wr |=> mode_q.tx_enable_bit == $past(bus_bit_val))
    else $error("bit 7 is not transmit enable");
  midi_rate_a: assert property (baud_q == 8'h59 |-> {half_bit(baud_q), 1'b0}
    == 13'(ASP_MIDI_CYC)) else $error("31.25 kbit/s setting wrong");
endmodule

// File: tb/asp_remote.sv
/*
  Remote serial transceiver standing on the far side of the serial pins.
  Assumes one frame at a time in each direction and a line that idles high.
*/
`timescale 1ns/1ps
module asp_remote (
  input wire logic clk_sys, // Bench clock
  input wire logic [15:0] bit_cyc, // Clocks per bit
  input wire logic nbits8, // Eight data bits
  input wire logic par_on, // Parity bit present
  input wire logic stop2, // Two stop bits
  input wire logic line_in, // From device transmit pin
  output logic line_out, // To device receive pin
  input wire logic go, // Send one frame
  input wire logic [7:0] go_byte, // Byte to send
  input wire logic go_par, // Parity bit to send
  input wire logic go_stop, // First stop bit level
  output logic got_stb, // Frame received pulse
  output logic [10:0] got_frame // Second stop, stop, parity, data
);
  // ****************
  // Transmit side
  // ****************
  task automatic send_bit(input logic b);
    line_out <= b;
    repeat (bit_cyc) @(posedge clk_sys);
  endtask

  initial begin
    line_out = 1'b1; // Pulled high between frames
    forever begin
      @(posedge clk_sys);
      if (go === 1'b1) begin
        send_bit(1'b0);
        for (int i = 0; i < (nbits8 ? 8 : 7); i++) send_bit(go_byte[i]);
        if (par_on) send_bit(go_par);
        send_bit(go_stop);
        if (stop2) send_bit(1'b1);
        line_out <= 1'b1;
      end
    end
  end

  // ****************
  // Receive side
  // ****************
  initial begin
    got_stb = 1'b0;
    got_frame = '0;
    forever begin : rx_loop
      logic [10:0] f;
      @(negedge line_in);
      f = 11'h600;
      repeat (bit_cyc / 2) @(posedge clk_sys);
      for (int i = 0; i < (nbits8 ? 8 : 7); i++) begin
        repeat (bit_cyc) @(posedge clk_sys);
        f[i] = line_in; // Least significant first
      end
      if (par_on) begin
        repeat (bit_cyc) @(posedge clk_sys);
        f[8] = line_in;
      end
      repeat (bit_cyc) @(posedge clk_sys);
      f[9] = line_in;
      if (stop2) begin
        repeat (bit_cyc) @(posedge clk_sys);
        f[10] = line_in;
      end
      got_frame <= f;
      got_stb <= 1'b1;
      @(posedge clk_sys);
      got_stb <= 1'b0;
    end
  end
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench for the asynchronous serial port.
  Assumes the remote model on the serial pins and the package register map.
*/
`timescale 1ns/1ps
module testbench;
  import asp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] bus_addr = '0;
  logic bus_wr = 1'b0, bus_rd = 1'b0, bus_bit_wr = 1'b0, bus_bit_val = 1'b0;
  logic [2:0] bus_bit_sel = '0;
  logic [7:0] bus_wdata = '0, bus_rdata_q, cur_mode = '0, go_byte = '0;
  logic tx_space_q, rx_avail_q, rx_event_q, serial_in_pin, serial_out_pin_q, serial_out_oe_n_q;
  logic go = 1'b0, go_par = 1'b0, go_stop = 1'b1, got_stb;
  logic [15:0] bit_cyc = 16'd64;
  logic [10:0] got_frame;
  logic [10:0] got[$];
  int err_total = 0, n_tests = 0, n_q;
  // Mode, data, frame on the wire {stop2, stop, parity, data}
  logic [26:0] rows [6] = '{{8'hC8, 8'hA5, 11'h6A5}, {8'hC0, 8'hA5, 11'h625},
    {8'hD8, 8'h3C, 11'h63C}, {8'hE8, 8'h3C, 11'h73C}, {8'hFC, 8'h07, 11'h707},
    {8'hE4, 8'hFF, 11'h67F}};

  asp_serial_port #(.FIFO_DEPTH(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_wr(bus_bit_wr),
    .bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val), .bus_wdata(bus_wdata),
    .bus_rdata_q(bus_rdata_q), .tx_space_q(tx_space_q), .rx_avail_q(rx_avail_q),
    .rx_event_q(rx_event_q), .serial_in_pin(serial_in_pin),
    .serial_out_pin_q(serial_out_pin_q), .serial_out_oe_n_q(serial_out_oe_n_q));

  asp_remote remote (.clk_sys(clk_sys), .bit_cyc(bit_cyc), .nbits8(cur_mode[3]),
    .par_on(cur_mode[5:4] != 2'h0), .stop2(cur_mode[2]), .line_in(serial_out_pin_q),
    .line_out(serial_in_pin), .go(go), .go_byte(go_byte), .go_par(go_par),
    .go_stop(go_stop), .got_stb(got_stb), .got_frame(got_frame));

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (got_stb === 1'b1) got.push_back(got_frame);
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic bw(input logic [2:0] s, input logic b);
    bus_addr <= ASP_ADDR_MODE;
    bus_bit_sel <= s;
    bus_bit_val <= b;
    bus_bit_wr <= 1'b1;
    @(posedge clk_sys);
    bus_bit_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(posedge clk_sys);
    chk(bus_rdata_q, exp);
  endtask

  task automatic fire(input logic [7:0] d, input logic p, input logic s);
    // The remote only looks at go while idle, so let its last frame finish
    repeat (2 * bit_cyc) @(posedge clk_sys);
    go_byte <= d;
    go_par <= p;
    go_stop <= s;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_ev();
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk_sys);
      if (rx_event_q === 1'b1) break;
    end
    if (i == 2000) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask

  task automatic wait_got(input int n, input int lim);
    for (int i = 0; i < lim && got.size() < n; i++) @(posedge clk_sys);
  endtask

  // Record the mode for the remote model, then write it to the mode register
  task automatic set_mode(input logic [7:0] m);
    cur_mode <= m;
    wr(ASP_ADDR_MODE, m);
  endtask

  task automatic wrap_up();
    $display("Checks: %0d, mismatches: %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk(serial_out_pin_q, 1'b1);
    chk(serial_out_oe_n_q, 1'b1);
    chk(tx_space_q, 1'b0);
    rdc(ASP_ADDR_MODE, 8'h00);
    rdc(ASP_ADDR_STAT, 8'h00);
    rdc(ASP_ADDR_BAUD, 8'h00);
    rdc(ASP_ADDR_DATA, 8'hFF);
    rdc(16'hFFA4, ASP_UNMAPPED);
    wr(ASP_ADDR_DATA, 8'h00);
    wait_got(1, 800);
    chk(11'(got.size()), 11'h0);
    rdc(ASP_ADDR_DATA, 8'hFF);
    bw(3'h7, 1'b1);
    bw(3'h6, 1'b1);
    bw(3'h0, 1'b1);
    rdc(ASP_ADDR_MODE, 8'hC0);
    chk(serial_out_oe_n_q, 1'b0);
    wr(ASP_ADDR_BAUD, 8'h90);
    rdc(ASP_ADDR_BAUD, 8'h10);
    foreach (rows[r]) begin
      set_mode(rows[r][26:19]);
      wr(ASP_ADDR_DATA, rows[r][18:11]);
      fire(rows[r][18:11], rows[r][8], 1'b1);
      wait_ev();
      wait_got(1, 1000); // Frame ends before the next write
      chk(got.pop_front(), rows[r][10:0]);
      rdc(ASP_ADDR_DATA, rows[r][7:0]);
      chk(rx_avail_q, 1'b0);
      rdc(ASP_ADDR_STAT, 8'h00);
      repeat (2 * bit_cyc) @(posedge clk_sys); // Both lines idle before the next write
    end
    set_mode(8'hE8);
    fire(8'h3C, 1'b0, 1'b1);
    wait_ev();
    rdc(ASP_ADDR_STAT, 8'h04);
    rdc(ASP_ADDR_STAT, 8'h00);
    rdc(ASP_ADDR_DATA, 8'h3C);
    fire(8'h55, 1'b1, 1'b0);
    wait_ev();
    rdc(ASP_ADDR_STAT, 8'h02);
    rdc(ASP_ADDR_DATA, 8'h55);
    // Error completion with the event suppressed: status set, no pulse
    set_mode(8'hEA);
    fire(8'h3C, 1'b0, 1'b1);
    n_q = 0;
    repeat (11 * 64) begin
      @(posedge clk_sys);
      if (rx_event_q === 1'b1) n_q++;
    end
    chk(11'(n_q), 11'h0);
    rdc(ASP_ADDR_STAT, 8'h04);
    rdc(ASP_ADDR_DATA, 8'h3C);
    set_mode(8'hC8);
    for (int i = 0; i < 4; i++) begin
      fire(8'hA0 + 8'(i), 1'b0, 1'b1);
      wait_ev();
      if (i == 2) rdc(ASP_ADDR_DATA, 8'hA0);
      if (i > 0) rdc(ASP_ADDR_STAT, (i == 3) ? 8'h00 : 8'h01);
    end
    rdc(ASP_ADDR_DATA, 8'hA3);
    n_q = 0;
    for (int i = 0; i < 8; i++) begin
      // Registered space flag needs one more edge to show the last push
      @(posedge clk_sys);
      if (tx_space_q === 1'b1) begin
        wr(ASP_ADDR_DATA, 8'hB0 + 8'(i));
        n_q++;
      end
    end
    wr(ASP_ADDR_DATA, 8'hEE);
    wait_got(n_q + 1, 9000);
    chk(11'(n_q >= 4), 11'h1);
    chk(11'(got.size()), 11'(n_q));
    for (int i = 0; i < n_q; i++) chk(got.pop_front(), 11'h6B0 + 11'(i));
    wr(ASP_ADDR_BAUD, 8'h59);
    bit_cyc <= 16'(ASP_MIDI_CYC);
    wr(ASP_ADDR_DATA, 8'h90);
    wait_got(1, 20000);
    chk(got.pop_front(), 11'h690);
    wrap_up();
  end

  initial begin
    #1_500_000;
    err_total++;
    wrap_up();
  end
endmodule
